// ===== hw/epph_pkg.sv
// Constants, modes and states for the parallel port enhanced-mode sequencer.
// Assumes a single 100 MHz core clock; users write epph_pkg::name.
package epph_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int WAIT_SETTLE_NS = 50;
   localparam int WAIT_SETTLE_CYC =
      (WAIT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMEOUT_US = 10000;
   localparam int TIMEOUT_CYC = TIMEOUT_US * 1000 / CLK_PERIOD_NS;
   localparam int PEER_SETTLE_NS = 80;
   localparam int PEER_SETTLE_CYC =
      (PEER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      EPPH_MODE_EPP17 = 2'b00,
      EPPH_MODE_EPP19 = 2'b01,
      EPPH_MODE_FIFO = 2'b10,
      EPPH_MODE_ECP = 2'b11
   } epph_mode_t;

   typedef enum logic [3:0] {
      EPPH_IDLE = 4'h0,
      EPPH_W_NWR = 4'h1,
      EPPH_W_STB = 4'h2,
      EPPH_R_WAIT = 4'h3,
      EPPH_R_FLOAT = 4'h4,
      EPPH_R_DIR = 4'h5,
      EPPH_R_STB = 4'h6,
      EPPH_END = 4'h7,
      EPPH_HOLD = 4'h8
   } epph_epp_t;

   typedef enum logic [2:0] {
      EPPH_FWD_IDLE = 3'h0,
      EPPH_FWD_STB = 3'h1,
      EPPH_FWD_REL = 3'h2,
      EPPH_REV_IDLE = 3'h3,
      EPPH_REV_ACK = 3'h4,
      EPPH_REV_DONE = 3'h5
   } epph_ecp_t;
endpackage : epph_pkg

// ===== hw/epph_filt.sv
// Three-flop synchroniser with stability filter for one cable input.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/10ps
module epph_filt #(
   parameter int SETTLE_CYC = 5,
   parameter bit RESET_VAL = 1'b1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic level_out
);
   localparam int CW = $clog2(SETTLE_CYC + 1);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic [CW-1:0] cnt_r;

   initial begin
      if (SETTLE_CYC < 1) begin
         $error("SETTLE_CYC must be at least 1");
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= RESET_VAL;
         s2_r <= RESET_VAL;
         s3_r <= RESET_VAL;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Accept a new level once it has held steady for the settle time
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         level_out <= RESET_VAL;
      end else if (s2_r != s3_r || s3_r == level_out) begin
         cnt_r <= '0;
      end else if (cnt_r == CW'(SETTLE_CYC - 1)) begin
         cnt_r <= '0;
         level_out <= s3_r;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule : epph_filt

// ===== hw/epph_isa_sync.sv
// Synchronises the ISA read and write strobes and flags while each is active.
// Assumes strobes are active low and asynchronous to core_clk.
`timescale 1ns/10ps
module epph_isa_sync (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ior_n,
   input wire logic iow_n,
   output logic rd_act,
   output logic wr_act
);
   logic [2:0] r_sh_r;
   logic [2:0] w_sh_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_sh_r <= 3'h7;
         w_sh_r <= 3'h7;
         rd_act <= 1'b0;
         wr_act <= 1'b0;
      end else begin
         r_sh_r <= {r_sh_r[1:0], ior_n};
         w_sh_r <= {w_sh_r[1:0], iow_n};
         if (r_sh_r[1] == r_sh_r[2]) begin
            rd_act <= ~r_sh_r[2];
         end
         if (w_sh_r[1] == w_sh_r[2]) begin
            wr_act <= ~w_sh_r[2];
         end
      end
   end
endmodule : epph_isa_sync

// ===== hw/epph_top.sv
// Enhanced-mode parallel port sequencer: EPP 1.7/1.9, FIFO and ECP.
// Assumes address decode elsewhere raises epp_sel with the ISA strobe and
// that the mode input is held steady while a transfer is under way.
`timescale 1ns/10ps
module epph_top #(
   parameter int TIMEOUT_CYC = epph_pkg::TIMEOUT_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [1:0] mode,
   input wire logic epp_sel,
   input wire logic ior_n,
   input wire logic iow_n,
   output logic iochrdy,
   input wire logic [7:0] system_data_bus,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic timeout,
   input wire logic port_direction_bit,
   input wire logic wait_n,
   input wire logic busy,
   input wire logic ack_n,
   input wire logic fault_n,
   input wire logic [7:0] port_data_in,
   output logic [7:0] port_data_lines,
   output logic port_data_oe,
   output logic write_n,
   output logic strobe_n,
   output logic autofd_n,
   output logic ext_dir,
   input wire logic fwd_valid,
   input wire logic [7:0] fwd_data,
   output logic fwd_ready,
   output logic [7:0] rev_data,
   output logic rev_valid,
   input wire logic rev_ready,
   input wire logic rev_req,
   output logic periph_req
);
   localparam int TW = $clog2(TIMEOUT_CYC + 1);
   localparam int SW = $clog2(epph_pkg::PEER_SETTLE_CYC + 1);

   logic rd_act;
   logic wr_act;
   logic wait_s;
   logic busy_s;
   logic ack_s;
   logic fault_s;
   logic [7:0] pdin_r1;
   logic [7:0] pdin_r2;
   logic [7:0] pdin_r3;
   epph_pkg::epph_epp_t epp_r;
   epph_pkg::epph_ecp_t ecp_r;
   logic [TW-1:0] tmo_r;
   logic [SW-1:0] gap_r;
   logic epp_strobe;
   logic ecp_strobe;
   logic is_epp;

   initial begin
      if (TIMEOUT_CYC < 2) begin
         $error("TIMEOUT_CYC must be at least 2");
      end
   end

   epph_isa_sync u_isa (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ior_n(ior_n),
      .iow_n(iow_n),
      .rd_act(rd_act),
      .wr_act(wr_act)
   );

   epph_filt #(.SETTLE_CYC(epph_pkg::WAIT_SETTLE_CYC), .RESET_VAL(1'b1))
   u_wait (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_in(wait_n),
      .level_out(wait_s)
   );

   epph_filt #(.SETTLE_CYC(epph_pkg::PEER_SETTLE_CYC), .RESET_VAL(1'b0))
   u_busy (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_in(busy),
      .level_out(busy_s)
   );

   epph_filt #(.SETTLE_CYC(epph_pkg::PEER_SETTLE_CYC), .RESET_VAL(1'b1))
   u_ack (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_in(ack_n),
      .level_out(ack_s)
   );

   epph_filt #(.SETTLE_CYC(epph_pkg::WAIT_SETTLE_CYC), .RESET_VAL(1'b1))
   u_fault (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_in(fault_n),
      .level_out(fault_s)
   );

   // Data bus samples; pdin_r1 feeds only pdin_r2
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pdin_r1 <= 8'h00;
         pdin_r2 <= 8'h00;
         pdin_r3 <= 8'h00;
      end else begin
         pdin_r1 <= port_data_in;
         pdin_r2 <= pdin_r1;
         pdin_r3 <= pdin_r2;
      end
   end

   assign is_epp = (mode == epph_pkg::EPPH_MODE_EPP17) ||
                   (mode == epph_pkg::EPPH_MODE_EPP19);

   // EPP cycle sequencing
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         epp_r <= epph_pkg::EPPH_IDLE;
      end else if (epp_r != epph_pkg::EPPH_IDLE &&
                   epp_r != epph_pkg::EPPH_HOLD &&
                   tmo_r == TW'(TIMEOUT_CYC - 1)) begin
         epp_r <= epph_pkg::EPPH_HOLD;
      end else begin
         unique case (epp_r)
            epph_pkg::EPPH_IDLE: begin
               if (is_epp && epp_sel && wr_act && !port_direction_bit) begin
                  epp_r <= epph_pkg::EPPH_W_NWR;
               end else if (is_epp && epp_sel && rd_act) begin
                  if (mode == epph_pkg::EPPH_MODE_EPP17) begin
                     epp_r <= epph_pkg::EPPH_R_STB;
                  end else begin
                     epp_r <= epph_pkg::EPPH_R_WAIT;
                  end
               end
            end
            epph_pkg::EPPH_W_NWR: epp_r <= epph_pkg::EPPH_W_STB;
            epph_pkg::EPPH_W_STB: begin
               if (mode == epph_pkg::EPPH_MODE_EPP17 && !wr_act) begin
                  epp_r <= epph_pkg::EPPH_HOLD;
               end else if (!wait_s) begin
                  epp_r <= epph_pkg::EPPH_END;
               end
            end
            epph_pkg::EPPH_R_WAIT: begin
               if (!wait_s) begin
                  epp_r <= epph_pkg::EPPH_R_FLOAT;
               end
            end
            epph_pkg::EPPH_R_FLOAT: epp_r <= epph_pkg::EPPH_R_DIR;
            epph_pkg::EPPH_R_DIR: epp_r <= epph_pkg::EPPH_R_STB;
            epph_pkg::EPPH_R_STB: begin
               if (mode == epph_pkg::EPPH_MODE_EPP17 && !rd_act) begin
                  epp_r <= epph_pkg::EPPH_HOLD;
               end else if (mode == epph_pkg::EPPH_MODE_EPP17 && !wait_s) begin
                  epp_r <= epph_pkg::EPPH_END;
               end else if (mode == epph_pkg::EPPH_MODE_EPP19 && wait_s) begin
                  epp_r <= epph_pkg::EPPH_END;
               end
            end
            // Release the host at once; HOLD waits for its strobe to end
            epph_pkg::EPPH_END: epp_r <= epph_pkg::EPPH_HOLD;
            epph_pkg::EPPH_HOLD: begin
               if (!rd_act && !wr_act) begin
                  epp_r <= epph_pkg::EPPH_IDLE;
               end
            end
            default: epp_r <= epph_pkg::EPPH_IDLE;
         endcase
      end
   end

   // Timeout counter runs while the peripheral is owed a handshake
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tmo_r <= '0;
         timeout <= 1'b0;
      end else begin
         timeout <= 1'b0;
         if (epp_r == epph_pkg::EPPH_IDLE || epp_r == epph_pkg::EPPH_HOLD) begin
            tmo_r <= '0;
         end else if (tmo_r == TW'(TIMEOUT_CYC - 1)) begin
            tmo_r <= '0;
            timeout <= 1'b1;
         end else begin
            tmo_r <= tmo_r + 1'b1;
         end
      end
   end

   // Captured read byte
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         if (epp_r == epph_pkg::EPPH_R_STB && epp_r != epph_pkg::EPPH_HOLD &&
             ((mode == epph_pkg::EPPH_MODE_EPP19 && wait_s) ||
              (mode == epph_pkg::EPPH_MODE_EPP17 && !wait_s))) begin
            rd_data <= pdin_r3;
            rd_valid <= 1'b1;
         end
      end
   end

   // ECP and FIFO handshake sequencing
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ecp_r <= epph_pkg::EPPH_FWD_IDLE;
         gap_r <= '0;
      end else begin
         if (gap_r != '0) begin
            gap_r <= gap_r - 1'b1;
         end
         unique case (ecp_r)
            epph_pkg::EPPH_FWD_IDLE: begin
               if (mode == epph_pkg::EPPH_MODE_ECP && rev_req) begin
                  ecp_r <= epph_pkg::EPPH_REV_IDLE;
               end else if (!is_epp && fwd_valid && !busy_s &&
                            gap_r == '0) begin
                  ecp_r <= epph_pkg::EPPH_FWD_STB;
               end
            end
            epph_pkg::EPPH_FWD_STB: begin
               if (busy_s) begin
                  ecp_r <= epph_pkg::EPPH_FWD_REL;
               end
            end
            epph_pkg::EPPH_FWD_REL: begin
               if (!busy_s) begin
                  ecp_r <= epph_pkg::EPPH_FWD_IDLE;
                  gap_r <= SW'(epph_pkg::PEER_SETTLE_CYC);
               end
            end
            epph_pkg::EPPH_REV_IDLE: begin
               if (mode != epph_pkg::EPPH_MODE_ECP || !rev_req) begin
                  ecp_r <= epph_pkg::EPPH_FWD_IDLE;
               end else if (!ack_s) begin
                  ecp_r <= epph_pkg::EPPH_REV_ACK;
               end
            end
            epph_pkg::EPPH_REV_ACK: begin
               if (ack_s) begin
                  ecp_r <= epph_pkg::EPPH_REV_DONE;
               end
            end
            epph_pkg::EPPH_REV_DONE: begin
               if (rev_ready) begin
                  ecp_r <= epph_pkg::EPPH_REV_IDLE;
               end
            end
            default: ecp_r <= epph_pkg::EPPH_FWD_IDLE;
         endcase
      end
   end

   // Reverse byte captured once, when nAck is first seen low in EPPH_REV_IDLE
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rev_data <= 8'h00;
      end else if (ecp_r == epph_pkg::EPPH_REV_IDLE && !ack_s) begin
         rev_data <= pdin_r3;
      end
   end

   assign rev_valid = (ecp_r == epph_pkg::EPPH_REV_DONE);
   assign fwd_ready = (ecp_r == epph_pkg::EPPH_FWD_REL) && !busy_s;
   assign periph_req = !fault_s && (mode == epph_pkg::EPPH_MODE_ECP);

   assign epp_strobe = (epp_r == epph_pkg::EPPH_W_STB) ||
                       (epp_r == epph_pkg::EPPH_R_STB);
   assign ecp_strobe = (ecp_r == epph_pkg::EPPH_FWD_STB);

   // Pin drive registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         write_n <= 1'b1;
         strobe_n <= 1'b1;
         autofd_n <= 1'b1;
         ext_dir <= 1'b0;
         port_data_oe <= 1'b1;
         port_data_lines <= 8'h00;
         iochrdy <= 1'b1;
      end else begin
         write_n <= !(epp_r == epph_pkg::EPPH_W_NWR ||
                      epp_r == epph_pkg::EPPH_W_STB);
         strobe_n <= !(epp_strobe || ecp_strobe);
         // Low only while waiting for a reverse byte; high once it is seen
         autofd_n <= (ecp_r != epph_pkg::EPPH_REV_IDLE);
         ext_dir <= (epp_r == epph_pkg::EPPH_R_DIR) ||
                    (epp_r == epph_pkg::EPPH_R_STB &&
                     mode == epph_pkg::EPPH_MODE_EPP19) ||
                    ecp_r == epph_pkg::EPPH_REV_IDLE ||
                    ecp_r == epph_pkg::EPPH_REV_ACK ||
                    ecp_r == epph_pkg::EPPH_REV_DONE;
         port_data_oe <= !(epp_r == epph_pkg::EPPH_R_FLOAT ||
                           epp_r == epph_pkg::EPPH_R_DIR ||
                           epp_r == epph_pkg::EPPH_R_STB ||
                           ecp_r == epph_pkg::EPPH_REV_IDLE ||
                           ecp_r == epph_pkg::EPPH_REV_ACK ||
                           ecp_r == epph_pkg::EPPH_REV_DONE);
         if (epp_r == epph_pkg::EPPH_IDLE && wr_act) begin
            port_data_lines <= system_data_bus;
         end else if (ecp_r == epph_pkg::EPPH_FWD_IDLE && fwd_valid) begin
            port_data_lines <= fwd_data;
         end
         iochrdy <= !(epp_r != epph_pkg::EPPH_IDLE &&
                      epp_r != epph_pkg::EPPH_HOLD);
      end
   end
endmodule : epph_top

// ===== test/epph_chk.sv
// Concurrent checks on the epph_top ports.
// Attached to every epph_top by the bind at the foot of this file.
`timescale 1ns/10ps
module epph_chk (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [1:0] mode,
   input wire logic epp_sel,
   input wire logic ior_n,
   input wire logic iow_n,
   input wire logic iochrdy,
   input wire logic timeout,
   input wire logic wait_n,
   input wire logic busy,
   input wire logic ack_n,
   input wire logic fault_n,
   input wire logic port_data_oe,
   input wire logic write_n,
   input wire logic strobe_n,
   input wire logic autofd_n,
   input wire logic ext_dir,
   input wire logic periph_req
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_wr_idle;
      iow_n [*8] |-> write_n;
   endproperty
   a_wr_idle: assert property (p_wr_idle) else $error("write_n low");
   property p_wr_first;
      $fell(strobe_n) && mode == 2'b00 && !iow_n |-> !$past(write_n);
   endproperty
   a_wr_first: assert property (p_wr_first) else $error("write late");
   property p_rd17;
      $fell(ior_n) && epp_sel && mode == 2'b00 |-> ##[1:8] !strobe_n;
   endproperty
   a_rd17: assert property (p_rd17) else $error("read strobe late");
   property p_rd19_lat;
      $fell(wait_n) && mode == 2'b01 && !ior_n && !iochrdy
         |-> ##[1:19] !strobe_n;
   endproperty
   a_rd19_lat: assert property (p_rd19_lat) else $error("slow strobe");
   property p_float;
      !strobe_n && ext_dir && mode == 2'b01 |-> !port_data_oe;
   endproperty
   a_float: assert property (p_float) else $error("data driven");
   property p_dir_set;
      $rose(ext_dir) && mode == 2'b01 |-> !port_data_oe && strobe_n && !wait_n;
   endproperty
   a_dir_set: assert property (p_dir_set) else $error("dir order");
   property p_fwd_rise;
      $rose(strobe_n) && mode[1] && !ext_dir |-> busy;
   endproperty
   a_fwd_rise: assert property (p_fwd_rise) else $error("early rise");
   property p_rev_idle;
      $fell(autofd_n) && mode == 2'b11 && ext_dir |-> ack_n;
   endproperty
   a_rev_idle: assert property (p_rev_idle) else $error("early fall");
   property p_req;
      (mode == 2'b11 && !fault_n) [*8] |-> ##[0:4] periph_req;
   endproperty
   a_req: assert property (p_req) else $error("request lost");
   property p_to_rel;
      timeout |-> ##[0:2] (iochrdy && strobe_n && write_n);
   endproperty
   a_to_rel: assert property (p_to_rel) else $error("not released");
endmodule : epph_chk

bind epph_top epph_chk u_chk (.core_clk, .rst_n, .mode, .epp_sel, .ior_n,
   .iow_n, .iochrdy, .timeout, .wait_n, .busy, .ack_n, .fault_n,
   .port_data_oe, .write_n, .strobe_n, .autofd_n, .ext_dir, .periph_req);

// ===== test/epph_peer.sv
// Behavioural cable peripheral for EPP, FIFO and ECP transfers.
// Acts just after core_clk edges; dly sets its answer time in cycles.
`timescale 1ns/10ps
module epph_peer (
   input wire logic core_clk,
   input wire logic [1:0] mode,
   input wire logic hold_off,
   input wire logic [3:0] dly,
   input wire logic [7:0] rd_byte,
   input wire logic [3:0] rev_num,
   input wire logic strobe_n,
   input wire logic write_n,
   input wire logic autofd_n,
   input wire logic ext_dir,
   input wire logic port_data_oe,
   input wire logic [7:0] port_data_lines,
   output logic wait_n,
   output logic busy,
   output logic ack_n,
   output logic [7:0] port_data_in,
   output logic [7:0] got_data,
   output logic got
);
   logic pen = 1'b0;
   logic [7:0] pdat = 8'h00;
   logic [7:0] junk = 8'h5a;
   int sent = 0;
   initial begin
      wait_n = 1'b1;
      busy = 1'b0;
      ack_n = 1'b1;
      got = 1'b0;
   end
   // Undriven lines wander so a stale byte cannot pass for good data
   assign port_data_in = port_data_oe ? port_data_lines : pen ? pdat : junk;
   always @(posedge core_clk) junk <= junk + 8'h3b;
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   always @(hold_off or mode)
      if (strobe_n)
         wait_n = ~mode[0] | hold_off;
   always begin
      @(negedge strobe_n);
      if (!mode[1]) begin
         pdat = rd_byte;
         pen = write_n;
         tick(dly);
         if (!hold_off) begin
            got_data = port_data_in;
            got = ~write_n;
            wait_n = mode[0];
            tick(1);
            got = 1'b0;
         end
         wait (strobe_n);
         tick(1);
         pen = 1'b0;
         wait_n = ~mode[0] | hold_off;
      end
   end
   always begin
      @(negedge strobe_n);
      if (mode[1] && !ext_dir) begin
         ack_n = mode[0];
         tick(dly);
         busy = 1'b1;
         wait (strobe_n);
         tick(dly);
         got_data = port_data_in;
         busy = 1'b0;
         ack_n = 1'b1;
         got = 1'b1;
         tick(1);
         got = 1'b0;
      end
   end
   always begin
      @(posedge core_clk);
      if (!ext_dir)
         sent = 0;
      else if (mode == 2'b11 && !autofd_n && sent < rev_num) begin
         #1;
         pdat = rd_byte + 8'(sent);
         pen = 1'b1;
         tick(dly);
         ack_n = 1'b0;
         wait (autofd_n);
         tick(dly);
         ack_n = 1'b1;
         wait (!autofd_n);
         pen = 1'b0;
         sent++;
      end
   end
endmodule : epph_peer

// ===== test/tb_epph_top.sv
// Self-checking bench for epph_top against the behavioural peripheral.
// Needs epph_pkg, the hw files, epph_peer and epph_chk compiled first.
`timescale 1ns/10ps
module tb_epph_top;
   logic core_clk = 1'b0, rst_n = 1'b0, epp_sel = 1'b0, ior_n = 1'b1;
   logic iow_n = 1'b1, port_direction_bit = 1'b0, fault_n = 1'b1;
   logic fwd_valid = 1'b0, rev_ready = 1'b0, rev_req = 1'b0;
   logic hold_off = 1'b0, saw_to = 1'b0;
   logic [1:0] mode = 2'b00;
   logic [3:0] dly = 4'h2, rev_num = 4'h0;
   logic [7:0] system_data_bus = 8'h00, fwd_data = 8'h00, rd_byte = 8'h00;
   logic iochrdy, rd_valid, timeout, wait_n, busy, ack_n, port_data_oe;
   logic write_n, strobe_n, autofd_n, ext_dir, fwd_ready, rev_valid;
   logic periph_req, got;
   logic [7:0] rd_data, port_data_in, port_data_lines, rev_data, got_data;
   logic [7:0] exp_q[$];
   int n_fail = 0, comparisons = 0, cyc = 0;

   epph_top #(.TIMEOUT_CYC(50)) dut (.core_clk, .rst_n, .mode, .epp_sel,
      .ior_n, .iow_n, .iochrdy, .system_data_bus, .rd_data, .rd_valid,
      .timeout, .port_direction_bit, .wait_n, .busy, .ack_n, .fault_n,
      .port_data_in, .port_data_lines, .port_data_oe, .write_n, .strobe_n,
      .autofd_n, .ext_dir, .fwd_valid, .fwd_data, .fwd_ready, .rev_data,
      .rev_valid, .rev_ready, .rev_req, .periph_req);
   epph_peer peer (.core_clk, .mode, .hold_off, .dly, .rd_byte, .rev_num,
      .strobe_n, .write_n, .autofd_n, .ext_dir, .port_data_oe,
      .port_data_lines, .wait_n, .busy, .ack_n, .port_data_in, .got_data,
      .got);

   always #5 core_clk = ~core_clk;
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask : check
   task automatic take(input logic [7:0] v);
      if (exp_q.size() == 0)
         check(1'b0, "extra byte");
      else
         check(v === exp_q.pop_front(), "data mismatch");
   endtask : take
   task automatic give_verdict();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   // Downstream stalls at random so a held reverse byte must wait
   always @(posedge core_clk) begin
      #1;
      rev_ready = 1'($urandom_range(1, 0));
   end
   always @(posedge core_clk) begin
      cyc++;
      if (timeout === 1'b1)
         saw_to = 1'b1;
      if (rd_valid === 1'b1)
         take(rd_data);
      if (got === 1'b1)
         take(got_data);
      if (rev_valid === 1'b1 && rev_ready === 1'b1)
         take(rev_data);
      if (cyc == 8000) begin
         n_fail++;
         give_verdict();
      end
   end
   // kind: 0 normal, 1 refused, 2 abandoned by the peripheral
   task automatic epp(input logic rd, input logic [7:0] d, input int kind);
      int n = 0;
      if (kind == 0)
         exp_q.push_back(rd ? rd_byte : d);
      system_data_bus = d;
      epp_sel = 1'b1;
      ior_n = !rd;
      iow_n = rd;
      while (iochrdy === 1'b1 && n < 12) begin
         tick(1);
         n++;
      end
      check((n == 12) == (kind == 1), "wait request");
      n = 0;
      while (iochrdy !== 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
      check(n < 300, "stuck wait");
      ior_n = 1'b1;
      iow_n = 1'b1;
      epp_sel = 1'b0;
      tick(12);
   endtask : epp
   task automatic send_fwd(input logic [7:0] d);
      int n = 0;
      tick(1);
      exp_q.push_back(d);
      fwd_data = d;
      fwd_valid = 1'b1;
      while (fwd_ready !== 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
      tick(1);
      fwd_valid = 1'b0;
      check(n < 300, "no ready");
   endtask : send_fwd

   initial begin
      void'($urandom(80192));
      tick(4);
      rst_n = 1'b1;
      tick(4);
      for (int k = 0; k < 4; k++) begin
         dly = 4'($urandom_range(4, 1));
         rd_byte = 8'($urandom);
         port_direction_bit = k[0];
         epp(k[0], 8'($urandom), 0);
      end
      port_direction_bit = 1'b1;
      epp(1'b0, 8'h3c, 1);
      $display("test epp17 done");
      mode = 2'b01;
      for (int k = 0; k < 2; k++) begin
         hold_off = k[0];
         tick(10);
         rd_byte = 8'($urandom);
         fork
            epp(1'b1, 8'h00, 0);
            begin
               tick(20);
               hold_off = 1'b0;
            end
         join
      end
      $display("test epp19 done");
      mode = 2'b00;
      port_direction_bit = 1'b0;
      hold_off = 1'b1;
      tick(10);
      epp(1'b0, 8'ha5, 2);
      hold_off = 1'b0;
      check(saw_to, "no timeout");
      $display("test timeout done");
      for (int m = 2; m < 4; m++) begin
         mode = 2'(m);
         for (int k = 0; k < 3; k++) begin
            fault_n = !(m == 3 && k == 1);
            send_fwd(8'($urandom));
         end
      end
      fault_n = 1'b1;
      $display("test forward done");
      rd_byte = 8'($urandom);
      rev_num = 4'h3;
      for (int k = 0; k < 3; k++)
         exp_q.push_back(rd_byte + 8'(k));
      rev_req = 1'b1;
      for (int n = 0; n < 600 && exp_q.size() != 0; n++)
         tick(1);
      check(exp_q.size() == 0, "reverse bytes");
      rev_req = 1'b0;
      tick(30);
      send_fwd(8'h96);
      tick(30);
      check(exp_q.size() == 0, "bytes missing");
      $display("test reverse done");
      give_verdict();
   end
endmodule : tb_epph_top
